// ---- sac_defines.vh ----
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// ----------------------------------------------------------------
// Register bus offsets
// ----------------------------------------------------------------
`define SAC_RB_CTL_OFF     20'h1d224
`define SAC_RB_STAT_OFF    20'h1d220

// ----------------------------------------------------------------
// Peripheral byte addresses seen by the external master
// ----------------------------------------------------------------
`define SAC_PA_WADDR       8'h00
`define SAC_PA_WDAT        8'h04
`define SAC_PA_WDAT_HI2    8'h05
`define SAC_PA_WDAT_HI4    8'h07
`define SAC_PA_RADDR       8'h10
`define SAC_PA_RDAT        8'h14
`define SAC_PA_RDAT_HI2    8'h15
`define SAC_PA_RDAT_HI4    8'h17
`define SAC_PA_STAT        8'h20
`define SAC_PA_CTL         8'h24
`define SAC_PA_CTL_END     8'h27

// ----------------------------------------------------------------
// Control field positions, little-endian bit numbers
// ----------------------------------------------------------------
`define SAC_CTL_READ_ACCESS_SIZE_HI   7
`define SAC_CTL_READ_ACCESS_SIZE_LO   6
`define SAC_CTL_WRITE_ACCESS_SIZE_HI   5
`define SAC_CTL_WRITE_ACCESS_SIZE_LO   4
`define SAC_CTL_READ_AUTO_INCREMENT       3
`define SAC_CTL_WRITE_AUTO_INCREMENT       2
`define SAC_STAT_OK        7

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define SAC_SIZE_1B        2'b00
`define SAC_SIZE_2B        2'b01
`define SAC_SIZE_4B        2'b10
`define SAC_SIZE_8B        2'b11
`define SAC_CTL_RESET      32'h000000a0
`define SAC_READ_ACCESS_SIZE_RESET    2'b10
`define SAC_WRITE_ACCESS_SIZE_RESET    2'b10
`define SAC_INC_STEP4      32'h00000004
`define SAC_INC_STEP2      32'h00000002

// Arbitrary default slave address
`define SAC_SLAVE_ADDR     7'h2a

`endif

// ---- sac_i2c_engine.v ----
`timescale 1ns/10ps
`include "sac_defines.vh"

module sac_i2c_engine (
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       scl_in,
	output wire       scl_oe_n,
	input  wire       sda_in,
	output wire       sda_oe_n,
	input  wire       stall,
	input  wire [7:0] rd_data,
	output reg        rd_req,
	output reg        rd_take,
	output reg        wr_byte,
	output reg        wr_first,
	output reg  [7:0] wr_data
);

	localparam [3:0] ST_IDLE  = 4'h0;
	localparam [3:0] ST_ADDR  = 4'h1;
	localparam [3:0] ST_ACKA  = 4'h2;
	localparam [3:0] ST_WBYTE = 4'h3;
	localparam [3:0] ST_ACKW  = 4'h4;
	localparam [3:0] ST_WHOLD = 4'h5;
	localparam [3:0] ST_RLOAD = 4'h6;
	localparam [3:0] ST_RBYTE = 4'h7;
	localparam [3:0] ST_RACK  = 4'h8;

	reg  [3:0] state;
	reg  [2:0] cnt;
	reg        got8;
	reg        rw;
	reg        first;
	reg        nack;
	reg        sda_low;
	reg  [7:0] shift;
	reg        scl_m;
	reg        scl_s;
	reg        scl_d;
	reg        sda_m;
	reg        sda_s;
	reg        sda_d;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_c;
	wire       stop_c;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	// Stretching only starts right after a falling edge, so the
	// master never sees its high phase cut short
	assign scl_oe_n = ~((state == ST_WHOLD) | (state == ST_RLOAD));
	assign sda_oe_n = ~sda_low;

	// ----------------------------------------------------------------
	// Byte engine
	// ----------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			cnt      <= 3'h0;
			got8     <= 1'b0;
			rw       <= 1'b0;
			first    <= 1'b0;
			nack     <= 1'b0;
			sda_low  <= 1'b0;
			shift    <= 8'h00;
			rd_req   <= 1'b0;
			rd_take  <= 1'b0;
			wr_byte  <= 1'b0;
			wr_first <= 1'b0;
			wr_data  <= 8'h00;
		end else begin
			rd_req  <= 1'b0;
			rd_take <= 1'b0;
			wr_byte <= 1'b0;
			if (start_c) begin
				state   <= ST_ADDR;
				cnt     <= 3'h0;
				got8    <= 1'b0;
				sda_low <= 1'b0;
			end else if (stop_c) begin
				state   <= ST_IDLE;
				sda_low <= 1'b0;
			end else begin
				case (state)
				ST_ADDR, ST_WBYTE: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda_s};
						cnt   <= cnt + 3'h1;
						if (cnt == 3'h7)
							got8 <= 1'b1;
					end else if (scl_fall && got8) begin
						got8 <= 1'b0;
						if (state == ST_ADDR) begin
							if (shift[7:1] == `SAC_SLAVE_ADDR) begin
								rw      <= shift[0];
								sda_low <= 1'b1;
								state   <= ST_ACKA;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							sda_low  <= 1'b1;
							wr_byte  <= 1'b1;
							wr_data  <= shift;
							wr_first <= first;
							first    <= 1'b0;
							state    <= ST_ACKW;
						end
					end
				end
				ST_ACKA: begin
					if (scl_fall) begin
						sda_low <= 1'b0;
						cnt     <= 3'h0;
						if (rw) begin
							rd_req <= 1'b1;
							state  <= ST_RLOAD;
						end else begin
							first <= 1'b1;
							state <= ST_WBYTE;
						end
					end
				end
				ST_ACKW: begin
					if (scl_fall) begin
						sda_low <= 1'b0;
						state   <= ST_WHOLD;
					end
				end
				ST_WHOLD: begin
					if (!stall) begin
						cnt   <= 3'h0;
						state <= ST_WBYTE;
					end
				end
				ST_RLOAD: begin
					if (!stall) begin
						shift   <= rd_data;
						sda_low <= ~rd_data[7];
						rd_take <= 1'b1;
						cnt     <= 3'h0;
						state   <= ST_RBYTE;
					end
				end
				ST_RBYTE: begin
					if (scl_fall) begin
						if (cnt == 3'h7) begin
							sda_low <= 1'b0;
							state   <= ST_RACK;
						end else begin
							sda_low <= ~shift[6];
							shift   <= {shift[6:0], 1'b0};
							cnt     <= cnt + 3'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						nack <= sda_s;
					end else if (scl_fall) begin
						if (nack) begin
							state <= ST_IDLE;
						end else begin
							rd_req <= 1'b1;
							state  <= ST_RLOAD;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule

// ---- sac_access_ctrl.v ----
`timescale 1ns/10ps
`include "sac_defines.vh"

module sac_access_ctrl (
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire        scl_in,
	output wire        scl_out,
	output wire        scl_oe_n,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe_n,
	input  wire        rb_rd,
	input  wire [19:0] rb_addr,
	output reg  [31:0] rb_rdata,
	output reg         ib_req,
	output reg         ib_we,
	output reg  [31:0] ib_addr,
	output reg  [31:0] ib_wdata,
	input  wire [31:0] ib_rdata,
	input  wire        ib_ack,
	input  wire        ib_err
);

	reg         rst_m;
	reg         rst_n;
	reg  [1:0]  read_access_size;
	reg  [1:0]  write_access_size;
	reg         read_auto_increment;
	reg         write_auto_increment;
	reg         access_success_flag;
	reg         busy;
	reg  [7:0]  ptr;
	reg  [31:0] waddr;
	reg  [31:0] wdata;
	reg  [31:0] raddr;
	reg  [31:0] rdata;
	reg  [31:0] pword;
	wire        rd_req;
	wire        rd_take;
	wire        wr_byte;
	wire        wr_first;
	wire [7:0]  wr_data;
	wire [7:0]  rd_byte;
	wire        stall;
	wire        r_ok;
	wire        w_ok;
	wire [7:0]  r_last;
	wire [7:0]  w_last;
	wire [31:0] r_step;
	wire [31:0] w_step;
	wire [31:0] ctl_word;
	wire [31:0] stat_word;
	wire [31:0] wdata_n;
	wire        launch_rd;
	wire        launch_wr;
	wire        ok_set;
	wire        ok_clr;
	wire        wr_data_byte;
	wire        rd_done;
	wire        wr_done;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	// Only the second stage is read by the rest of the block
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_n <= rst_m;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// ----------------------------------------------------------------
	// Serial byte engine
	// ----------------------------------------------------------------
	sac_i2c_engine u_engine (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.scl_in   (scl_in),
		.scl_oe_n (scl_oe_n),
		.sda_in   (sda_in),
		.sda_oe_n (sda_oe_n),
		.stall    (stall),
		.rd_data  (rd_byte),
		.rd_req   (rd_req),
		.rd_take  (rd_take),
		.wr_byte  (wr_byte),
		.wr_first (wr_first),
		.wr_data  (wr_data)
	);

	// ----------------------------------------------------------------
	// Engine hold-off
	// ----------------------------------------------------------------
	// No timeout on the internal bus: a target that never answers
	// keeps the serial clock stretched until the next reset
	// Request pulses stall too, so the engine cannot slip past an
	// access in the cycle before busy is visible
	assign stall = busy | rd_req | wr_byte;

	// ----------------------------------------------------------------
	// Size decode
	// ----------------------------------------------------------------
	assign r_ok = (read_access_size == `SAC_SIZE_2B) | (read_access_size == `SAC_SIZE_4B);
	assign w_ok = (write_access_size == `SAC_SIZE_2B) | (write_access_size == `SAC_SIZE_4B);
	assign r_last = (read_access_size == `SAC_SIZE_4B) ? `SAC_PA_RDAT_HI4 :
			`SAC_PA_RDAT_HI2;
	assign w_last = (write_access_size == `SAC_SIZE_4B) ? `SAC_PA_WDAT_HI4 :
			`SAC_PA_WDAT_HI2;
	assign r_step = (read_access_size == `SAC_SIZE_4B) ? `SAC_INC_STEP4 :
			`SAC_INC_STEP2;
	assign w_step = (write_access_size == `SAC_SIZE_4B) ? `SAC_INC_STEP4 :
			`SAC_INC_STEP2;

	// ----------------------------------------------------------------
	// Control and status words
	// ----------------------------------------------------------------
	assign ctl_word  = {24'h000000, read_access_size, write_access_size, read_auto_increment, write_auto_increment, 2'b00};
	assign stat_word = {24'h000000, access_success_flag, 7'h00};

	// ----------------------------------------------------------------
	// Peripheral byte map
	// ----------------------------------------------------------------
	always @* begin
		case (ptr[7:2])
		`SAC_PA_WADDR >> 2: pword = waddr;
		`SAC_PA_WDAT >> 2:  pword = wdata;
		`SAC_PA_RADDR >> 2: pword = raddr;
		`SAC_PA_RDAT >> 2:  pword = rdata;
		`SAC_PA_STAT >> 2:  pword = stat_word;
		`SAC_PA_CTL >> 2:   pword = ctl_word;
		default:            pword = 32'h00000000;
		endcase
	end

	assign rd_byte = pword[{ptr[1:0], 3'b000} +: 8];

	// ----------------------------------------------------------------
	// Byte lane merge
	// ----------------------------------------------------------------
	function [31:0] put_byte;
		input [31:0] word;
		input [1:0]  lane;
		input [7:0]  data;
		reg   [31:0] w;
		begin
			w = word;
			w[{lane, 3'b000} +: 8] = data;
			put_byte = w;
		end
	endfunction

	// ----------------------------------------------------------------
	// Launch and completion decode
	// ----------------------------------------------------------------
	assign wr_data_byte = wr_byte & ~wr_first;
	assign rd_done = ib_req & ib_ack & ~ib_we;
	assign wr_done = ib_req & ib_ack & ib_we;
	assign wdata_n = put_byte(wdata, ptr[1:0], wr_data);

	assign launch_rd = rd_req & (ptr == `SAC_PA_RDAT) & r_ok & ~busy;
	assign launch_wr = wr_data_byte & (ptr == w_last) & w_ok & ~busy;
	assign ok_set = (rd_done | wr_done) & ~ib_err;
	assign ok_clr = (rd_take & (ptr == `SAC_PA_STAT)) | launch_rd | launch_wr;

	// ----------------------------------------------------------------
	// Pointer and window registers
	// ----------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr   <= 8'h00;
			waddr <= 32'h00000000;
			wdata <= 32'h00000000;
			raddr <= 32'h00000000;
			read_access_size <= `SAC_READ_ACCESS_SIZE_RESET;
			write_access_size <= `SAC_WRITE_ACCESS_SIZE_RESET;
			read_auto_increment  <= 1'b0;
			write_auto_increment  <= 1'b0;
		end else begin
			if (wr_byte && wr_first) begin
				ptr <= wr_data;
			end else if (wr_byte) begin
				case (ptr[7:2])
				`SAC_PA_WADDR >> 2: waddr <= put_byte(waddr, ptr[1:0], wr_data);
				`SAC_PA_WDAT >> 2:  wdata <= wdata_n;
				`SAC_PA_RADDR >> 2: raddr <= put_byte(raddr, ptr[1:0], wr_data);
				`SAC_PA_CTL >> 2: begin
					if (ptr == `SAC_PA_CTL) begin
						read_access_size <= wr_data[`SAC_CTL_READ_ACCESS_SIZE_HI:`SAC_CTL_READ_ACCESS_SIZE_LO];
						write_access_size <= wr_data[`SAC_CTL_WRITE_ACCESS_SIZE_HI:`SAC_CTL_WRITE_ACCESS_SIZE_LO];
						read_auto_increment  <= wr_data[`SAC_CTL_READ_AUTO_INCREMENT];
						write_auto_increment  <= wr_data[`SAC_CTL_WRITE_AUTO_INCREMENT];
					end
				end
				default: begin
				end
				endcase
				if (w_ok && ptr == w_last)
					ptr <= `SAC_PA_WDAT;
				else
					ptr <= ptr + 8'h01;
			end else if (rd_take) begin
				// Wrap holds even with increment off, giving repeat reads
				if (r_ok && ptr == r_last)
					ptr <= `SAC_PA_RDAT;
				else
					ptr <= ptr + 8'h01;
			end
			// With its auto-increment bit set, any acknowledged access steps its address, failed or not
			if (rd_done && read_auto_increment)
				raddr <= raddr + r_step;
			if (wr_done && write_auto_increment)
				waddr <= waddr + w_step;
		end
	end

	// ----------------------------------------------------------------
	// Internal bus master
	// ----------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ib_req   <= 1'b0;
			ib_we    <= 1'b0;
			ib_addr  <= 32'h00000000;
			ib_wdata <= 32'h00000000;
			rdata    <= 32'h00000000;
			busy     <= 1'b0;
		end else if (ib_req) begin
			if (ib_ack) begin
				ib_req <= 1'b0;
				busy   <= 1'b0;
				if (!ib_we)
					rdata <= ib_rdata;
			end
		end else if (launch_rd) begin
			ib_req  <= 1'b1;
			ib_we   <= 1'b0;
			ib_addr <= raddr;
			busy    <= 1'b1;
		end else if (launch_wr) begin
			ib_req   <= 1'b1;
			ib_we    <= 1'b1;
			ib_addr  <= waddr;
			ib_wdata <= wdata_n;
			busy     <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Success flag, set beats clear
	// ----------------------------------------------------------------
	// Each launch clears it, so it reports only the latest access
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			access_success_flag <= 1'b0;
		else if (ok_set)
			access_success_flag <= 1'b1;
		else if (ok_clr)
			access_success_flag <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Register bus read port, never clears the flag
	// ----------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rb_rdata <= 32'h00000000;
		end else if (rb_rd) begin
			if (rb_addr == `SAC_RB_CTL_OFF)
				rb_rdata <= ctl_word;
			else if (rb_addr == `SAC_RB_STAT_OFF)
				rb_rdata <= stat_word;
			else
				rb_rdata <= 32'h00000000;
		end
	end

endmodule

// ---- sac_i2c_mst.sv ----
`timescale 1ns/10ps

module sac_i2c_mst (
	input  wire scl,
	input  wire sda,
	output reg  scl_o,
	output reg  sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Release SCL, sit out any stretch, then hold the high phase
	task rise;
		begin
			scl_o = 1'b1;
			wait (scl === 1'b1);
			#100;
		end
	endtask

	// Data moves 50 ns after SCL falls and is sampled late in the high
	// phase, leaving room for the slave's input synchronisers
	task bit_cyc(input b, output r);
		begin
			sda_o = b;
			#50;
			rise;
			r = sda;
			scl_o = 1'b0;
			#50;
		end
	endtask

	task start;
		begin
			sda_o = 1'b1;
			#100;
			rise;
			sda_o = 1'b0;
			#100;
			scl_o = 1'b0;
			#50;
		end
	endtask

	task stop;
		begin
			sda_o = 1'b0;
			#50;
			rise;
			sda_o = 1'b1;
			#100;
		end
	endtask

	task wr(input [7:0] d, output ack);
		integer i;
		reg     r;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bit_cyc(d[i], r);
			bit_cyc(1'b1, r);
			ack = ~r;
		end
	endtask

	task rd(input nak, output [7:0] d);
		integer i;
		reg     r;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bit_cyc(1'b1, d[i]);
			bit_cyc(nak, r);
		end
	endtask
endmodule

// ---- sac_access_ctrl_checker.sv ----
`timescale 1ns/10ps

module sac_chk (
	input wire        core_clk,
	input wire        rst_b,
	input wire        scl_out,
	input wire        scl_oe_n,
	input wire        sda_out,
	input wire        sda_oe_n,
	input wire        rb_rd,
	input wire [19:0] rb_addr,
	input wire [31:0] rb_rdata,
	input wire        ib_req,
	input wire        ib_we,
	input wire [31:0] ib_addr,
	input wire [31:0] ib_wdata,
	input wire        ib_ack
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_done;
		ib_req && ib_ack;
	endsequence
	// Waiting request, excluding the cycle just after a completion
	sequence s_wait;
		ib_req && !ib_ack && !$past(ib_ack);
	endsequence
	sequence s_ctl_rd;
		rb_rd && rb_addr == 20'h1d224;
	endsequence

	req_hold_a: assert property (s_wait |=> ib_req && $stable(ib_we)
		&& $stable(ib_addr) && $stable(ib_wdata))
		else $error("internal request changed before completion");
	req_drop_a: assert property (s_done |=> !ib_req)
		else $error("internal request held after completion");
	ctl_resv_a: assert property (s_ctl_rd |=>
		rb_rdata[31:8] == 24'h0 && rb_rdata[1:0] == 2'b00)
		else $error("reserved control bits not zero");
	unmapped_zero_a: assert property (rb_rd && rb_addr != 20'h1d224
		&& rb_addr != 20'h1d220 |=> rb_rdata == 32'h0)
		else $error("unmapped bus read not zero");
	rdata_stand_a: assert property (!rb_rd |=> $stable(rb_rdata))
		else $error("bus read data moved without a read");
	reset_idle_a: assert property ($rose(rst_b) |-> !ib_req
		&& scl_oe_n && sda_oe_n)
		else $error("outputs not idle at reset release");
	od_low_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("open drain data not low");
	stretch_rd_a: assert property (ib_req && !ib_we && !ib_ack
		&& $past(ib_req && !ib_ack) |-> !scl_oe_n)
		else $error("serial clock not held during internal read");
endmodule

bind sac_access_ctrl sac_chk u_chk (
	.core_clk(core_clk), .rst_b(rst_b), .scl_out(scl_out),
	.scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.rb_rd(rb_rd), .rb_addr(rb_addr), .rb_rdata(rb_rdata),
	.ib_req(ib_req), .ib_we(ib_we), .ib_addr(ib_addr),
	.ib_wdata(ib_wdata), .ib_ack(ib_ack));

// ---- tb.sv ----
`timescale 1ns/10ps
`include "sac_defines.vh"

module tb;
	reg         core_clk = 1'b0;
	reg         rst_b = 1'b0;
	reg         rb_rd = 1'b0;
	reg  [19:0] rb_addr = 20'h0;
	reg  [31:0] ib_rdata = 32'h0;
	reg         ib_ack = 1'b0;
	reg         ib_err = 1'b0;
	wire        scl_out, scl_oe_n, sda_out, sda_oe_n;
	wire        ib_req, ib_we, m_scl, m_sda;
	wire [31:0] rb_rdata, ib_addr, ib_wdata;
	wire        scl = m_scl & (scl_oe_n | scl_out);
	wire        sda = m_sda & (sda_oe_n | sda_out);
	integer     n_errors = 0, n_checks = 0, lat = 0, wt = 0;
	integer     n_rd = 0, n_wr = 0, r0, w0, i;
	reg  [31:0] wa, wd, w;
	reg  [63:0] v;
	reg         ack;
	// Rows: control byte written, control byte expected back
	localparam [63:0] ROWS = 64'hfffc_0300_5e5c_a0a0;
	localparam [31:0] K = 32'h5a5a0000;

	sac_access_ctrl u_dut (
		.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .rb_rd(rb_rd),
		.rb_addr(rb_addr), .rb_rdata(rb_rdata), .ib_req(ib_req),
		.ib_we(ib_we), .ib_addr(ib_addr), .ib_wdata(ib_wdata),
		.ib_rdata(ib_rdata), .ib_ack(ib_ack), .ib_err(ib_err));
	sac_i2c_mst u_mst (.scl(scl), .sda(sda), .scl_o(m_scl), .sda_o(m_sda));

	always #12.5 core_clk = ~core_clk;

	// Internal bus target; lat sets how long each access is kept waiting
	always @(negedge core_clk) begin
		ib_ack <= 1'b0;
		if (ib_req === 1'b1 && ib_ack === 1'b0) begin
			if (wt >= lat) begin
				wt = 0;
				ib_ack <= 1'b1;
				ib_rdata <= ib_addr ^ K;
				if (ib_we) begin
					n_wr = n_wr + 1;
					wa = ib_addr;
					wd = ib_wdata;
				end else
					n_rd = n_rd + 1;
			end else
				wt = wt + 1;
		end
	end

	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task rb_read(input [19:0] a);
		begin
			@(negedge core_clk);
			rb_addr = a;
			rb_rd = 1'b1;
			@(negedge core_clk);
			rb_rd = 1'b0;
			@(negedge core_clk);
			w = rb_rdata;
		end
	endtask

	task i2c_wr(input [7:0] p, input integer n, input [95:0] d);
		integer j;
		begin
			u_mst.start;
			u_mst.wr({`SAC_SLAVE_ADDR, 1'b0}, ack);
			u_mst.wr(p, ack);
			for (j = 0; j < n; j = j + 1)
				u_mst.wr(d[8*j +: 8], ack);
			u_mst.stop;
		end
	endtask

	task i2c_rd(input [7:0] p, input integer n);
		integer j;
		begin
			u_mst.start;
			u_mst.wr({`SAC_SLAVE_ADDR, 1'b0}, ack);
			u_mst.wr(p, ack);
			u_mst.start;
			u_mst.wr({`SAC_SLAVE_ADDR, 1'b1}, ack);
			v = 64'h0;
			for (j = 0; j < n; j = j + 1)
				u_mst.rd(j == n - 1, v[8*j +: 8]);
			u_mst.stop;
		end
	endtask

	task tally_and_finish;
		begin
			$display("Checks %0d, mismatches %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	initial begin
		#2000000;
		n_errors = n_errors + 1;
		tally_and_finish;
	end

	initial begin
		repeat (16) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge core_clk);
		rb_read(`SAC_RB_CTL_OFF);
		chk(w, 32'h000000a0);
		rb_read(`SAC_RB_STAT_OFF);
		chk(w, 32'h0);
		rb_read(20'h1d000);
		chk(w, 32'h0);
		for (i = 3; i >= 0; i = i - 1) begin
			i2c_wr(8'h24, 4, {64'h0, 24'hffffff, ROWS[16*i+8 +: 8]});
			rb_read(`SAC_RB_CTL_OFF);
			chk(w, {24'h0, ROWS[16*i +: 8]});
			i2c_rd(8'h24, 4);
			chk(v[31:0], {24'h0, ROWS[16*i +: 8]});
		end
		i2c_wr(8'h24, 1, 96'hac);
		i2c_wr(8'h00, 12, 96'h55667788_11223344_00000100);
		chk(n_wr, 2);
		chk(wa, 32'h104);
		chk(wd, 32'h55667788);
		lat = 5;
		i2c_wr(8'h10, 4, 96'h200);
		i2c_rd(8'h14, 8);
		chk(v[31:0], 32'h200 ^ K);
		chk(v[63:32], 32'h204 ^ K);
		chk(n_rd, 2);
		rb_read(`SAC_RB_STAT_OFF);
		chk(w, 32'h80);
		rb_read(`SAC_RB_STAT_OFF);
		chk(w, 32'h80);
		i2c_rd(8'h20, 1);
		chk(v[31:0], 32'h80);
		i2c_rd(8'h20, 1);
		chk(v[31:0], 32'h0);
		i2c_wr(8'h24, 1, 96'ha0);
		i2c_rd(8'h14, 8);
		chk(v[31:0], 32'h208 ^ K);
		chk(v[63:32], 32'h208 ^ K);
		i2c_wr(8'h04, 8, 96'h0badf00d_cafe0001);
		chk(wa, 32'h108);
		chk(n_wr, 4);
		@(negedge core_clk);
		ib_err = 1'b1;
		i2c_rd(8'h14, 1);
		@(negedge core_clk);
		ib_err = 1'b0;
		rb_read(`SAC_RB_STAT_OFF);
		chk(w, 32'h0);
		for (i = 0; i < 2; i = i + 1) begin
			i2c_wr(8'h24, 1, i ? 96'hf0 : 96'h00);
			r0 = n_rd;
			w0 = n_wr;
			i2c_wr(8'h04, 4, 96'h12345678);
			i2c_rd(8'h14, 1);
			chk(n_wr, w0);
			chk(n_rd, r0);
		end
		@(negedge core_clk);
		rst_b = 1'b0;
		repeat (4) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge core_clk);
		rb_read(`SAC_RB_CTL_OFF);
		chk(w, 32'h000000a0);
		tally_and_finish;
	end
endmodule
